// ---- hdl/mgb_bank.sv ----
// Purpose: Sixteen multifunction open-drain pins with per-pin config.
// Assumes: Pad inputs are asynchronous to i_clock; pads are wired-AND.
// Notes:   A function that a pin does not offer leaves its pad released.
// Operation
// [R01] Every pin is two-way with an open-drain driver that only pulls low.
// [R02] In plain I/O mode software sets a low or high output level.
// [R03] In plain I/O mode the sampled pin level is readable as status.
// [R04] In plain I/O mode a pin can blink an LED at selectable rates.
// [R05] An input pin with interrupt enabled flags pending on any change.
// [R06] Exposing internal signals turns the pin driver on automatically.
// [R07] The second config field picks which internal signal is exposed.
// [R08] All pin behaviour comes from that pin's own configuration pair.
// [R09] After reset pins 2 and 3 carry slave two-wire data and clock.
// [R10] After reset every other pin is in plain I/O mode.
// [R11] The two-wire master is usable only with both its pins assigned.
// [R12] Pending stays until cleared; change is synced level vs last sample.
// [R13] Function and internal-signal selector codes are local choices.
`timescale 1ns/10ps
module mgb_bank #(
  parameter int PINS        = mgb_pkg::PIN_COUNT,
  parameter int OBS         = mgb_pkg::OBS_COUNT,
  parameter int BLINK_HALF  = mgb_pkg::BLINK_BASE_CYCLES
) (
  input  wire logic                          i_clock,
  input  wire logic                          i_reset,
  input  wire logic        [PINS-1:0]        i_pin,
  output logic             [PINS-1:0]        o_pin,
  output logic             [PINS-1:0]        o_pin_oe,
  input  wire logic                          i_cfg_write,
  input  wire logic [mgb_pkg::PIN_IDX_W-1:0] i_cfg_pin,
  input  wire mgb_pkg::mgb_cfg_t             i_cfg_data,
  input  wire logic [mgb_pkg::PIN_IDX_W-1:0] i_read_pin,
  output mgb_pkg::mgb_status_t               o_read_data,
  input  wire logic        [PINS-1:0]        i_irq_clear,
  output logic             [PINS-1:0]        o_irq_pending,
  output logic             [PINS-1:0]        o_pin_level,
  input  wire logic        [OBS-1:0]         i_observe,
  input  wire logic                          i_slave_sda_pull,
  output logic                               o_slave_sda,
  output logic                               o_slave_scl,
  input  wire logic        [1:0]             i_master_sda_pull,
  input  wire logic        [1:0]             i_master_scl_pull,
  output logic             [1:0]             o_master_sda,
  output logic             [1:0]             o_master_scl,
  output logic             [1:0]             o_master_ready,
  output logic             [1:0]             o_module_absent,
  input  wire logic                          i_perf_monitor_tick,
  input  wire logic                          i_wan_sublayer_irq_a,
  input  wire logic                          i_wan_sublayer_irq_b,
  input  wire logic                          i_tx_activity,
  input  wire logic                          i_rx_activity,
  input  wire logic        [PINS-1:0]        i_aux_out,
  output logic             [PINS-1:0]        o_aux_in
);

  if (PINS != mgb_pkg::PIN_COUNT) begin : g_bad_pins
    $error("mgb_bank: pin-specific maps serve exactly sixteen pins.");
  end
  if (OBS != mgb_pkg::OBS_COUNT) begin : g_bad_obs
    $error("mgb_bank: observe width must match the selector field.");
  end
  if (BLINK_HALF < 1) begin : g_bad_blink
    $error("mgb_bank: BLINK_HALF must be at least one.");
  end

  mgb_pkg::mgb_cfg_t         cfg      [PINS];
  mgb_pkg::mgb_cfg_t         next_cfg [PINS];
  logic [PINS-1:0]           sync1;
  logic [PINS-1:0]           sync2;
  logic [PINS-1:0]           prev;
  logic [PINS-1:0]           pending;
  logic [PINS-1:0]           next_pending;
  logic [PINS-1:0]           pull;
  logic [PINS-1:0]           next_pull;
  logic [PINS-1:0]           offered;
  logic [mgb_pkg::RATE_COUNT-1:0] blink;
  mgb_pkg::mgb_status_t      next_read;
  logic [1:0]                next_master_ready;
  logic [1:0]                next_module_absent;

  // A single shared generator keeps every blinking plain I/O pin in phase.
  mgb_blink #(
    .HALF_CYCLES (BLINK_HALF),
    .RATES       (mgb_pkg::RATE_COUNT)
  ) u_blink (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .o_phase (blink)
  );

  // True when pin p is set to function f.
  function automatic logic is_func(input mgb_pkg::mgb_cfg_t c,
                                   input mgb_pkg::mgb_func_t f);
    is_func = (c.func == f);
  endfunction : is_func

  // True when pin p offers function f.
  // Activity LEDs alternate: transmit on even pins, receive on odd pins.
  function automatic logic pin_offers(input mgb_pkg::mgb_func_t f,
                                      input int p);
    case (f)
      mgb_pkg::FN_IO:
        pin_offers = 1'b1;
      mgb_pkg::FN_OBSERVE:
        pin_offers = 1'b1;
      mgb_pkg::FN_SLAVE_TWI:
        pin_offers = mgb_pkg::SLAVE_SDA_PINS[p]
                     || mgb_pkg::SLAVE_SCL_PINS[p];
      mgb_pkg::FN_MASTER_TWI:
        pin_offers = mgb_pkg::MASTER_PINS[p];
      mgb_pkg::FN_MOD_ABS:
        pin_offers = mgb_pkg::MOD_ABS_PINS[p];
      mgb_pkg::FN_TX_LED:
        pin_offers = (p % 2 == 0);
      mgb_pkg::FN_RX_LED:
        pin_offers = (p % 2 == 1);
      mgb_pkg::FN_WAN_IRQ:
        pin_offers = 1'b1;
      mgb_pkg::FN_TICK:
        pin_offers = mgb_pkg::TICK_PINS[p];
      mgb_pkg::FN_AUX:
        pin_offers = 1'b1;
      default:
        pin_offers = 1'b0;
    endcase
  endfunction : pin_offers

  // Per-pin drive decision; returns 1 when the pin must be pulled low.
  function automatic logic want_low(input mgb_pkg::mgb_cfg_t c,
                                    input int p,
                                    input logic [OBS-1:0] obs,
                                    input logic [3:0] ph,
                                    input logic [1:0] msda,
                                    input logic [1:0] mscl,
                                    input logic sspull,
                                    input logic tick,
                                    input logic irqa,
                                    input logic irqb,
                                    input logic txa,
                                    input logic rxa,
                                    input logic aux);
    logic ch;
    ch = (p >= mgb_pkg::MASTER1_SDA_PIN);
    case (c.func) // R13
      mgb_pkg::FN_IO: begin
        if (!c.drive_en)
          want_low = 1'b0;
        else if (c.led_en)
          want_low = ph[c.blink_rate]; // R04
        else
          want_low = !c.level; // R02
      end
      mgb_pkg::FN_OBSERVE:
        want_low = !obs[c.signal_select]; // R06 R07
      mgb_pkg::FN_SLAVE_TWI:
        want_low = mgb_pkg::SLAVE_SDA_PINS[p] && sspull;
      mgb_pkg::FN_MASTER_TWI: begin
        if (!mgb_pkg::MASTER_PINS[p])
          want_low = 1'b0;
        else if (p == mgb_pkg::MASTER0_SDA_PIN
                 || p == mgb_pkg::MASTER1_SDA_PIN)
          want_low = msda[ch];
        else
          want_low = mscl[ch];
      end
      mgb_pkg::FN_TX_LED:
        want_low = txa;
      mgb_pkg::FN_RX_LED:
        want_low = rxa;
      mgb_pkg::FN_WAN_IRQ:
        want_low = mgb_pkg::IRQ_B_PINS[p] ? irqb : irqa;
      mgb_pkg::FN_TICK:
        want_low = mgb_pkg::TICK_PINS[p] && tick;
      mgb_pkg::FN_AUX:
        want_low = !aux;
      default:
        want_low = 1'b0;
    endcase
  endfunction : want_low

  // Configuration registers, one pair per pin.
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      next_cfg[p] = cfg[p];
      if (i_cfg_write && i_cfg_pin == mgb_pkg::PIN_IDX_W'(p))
        next_cfg[p] = i_cfg_data; // R08
    end
  end

  generate
    for (genvar g = 0; g < PINS; g++) begin : g_cfg
      always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
          if (g == mgb_pkg::SLAVE_SDA_PIN || g == mgb_pkg::SLAVE_SCL_PIN)
            cfg[g] <= mgb_pkg::CFG_RESET_SLAVE; // R09
          else
            cfg[g] <= mgb_pkg::CFG_RESET_IO; // R10
        end else begin
          cfg[g] <= next_cfg[g];
        end
      end
    end
  endgenerate

  // Input sampling and change interrupts.
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      next_pending[p] = pending[p] && !i_irq_clear[p]; // R12
      if (is_func(cfg[p], mgb_pkg::FN_IO) && !cfg[p].drive_en
          && cfg[p].irq_en && (sync2[p] != prev[p]))
        next_pending[p] = 1'b1; // R05 R12
    end
  end

  // A refused function must never pull, whatever its source signal does.
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      offered[p] = pin_offers(cfg[p].func, p);
    end
  end

  // Pin drivers; they only ever pull low.
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      next_pull[p] = offered[p] && want_low(cfg[p], p, i_observe, blink,
                              i_master_sda_pull, i_master_scl_pull,
                              i_slave_sda_pull, i_perf_monitor_tick,
                              i_wan_sublayer_irq_a, i_wan_sublayer_irq_b,
                              i_tx_activity, i_rx_activity, i_aux_out[p]);
    end
  end

  // Master ports and module-absent inputs follow pin assignment.
  always_comb begin
    next_master_ready[0] =
      is_func(cfg[mgb_pkg::MASTER0_SDA_PIN], mgb_pkg::FN_MASTER_TWI)
      && is_func(cfg[mgb_pkg::MASTER0_SCL_PIN], mgb_pkg::FN_MASTER_TWI);
    next_master_ready[1] =
      is_func(cfg[mgb_pkg::MASTER1_SDA_PIN], mgb_pkg::FN_MASTER_TWI)
      && is_func(cfg[mgb_pkg::MASTER1_SCL_PIN], mgb_pkg::FN_MASTER_TWI);
    next_module_absent[0] = 1'b0;
    if (is_func(cfg[mgb_pkg::MOD_ABS0_PIN_A], mgb_pkg::FN_MOD_ABS))
      next_module_absent[0] = sync2[mgb_pkg::MOD_ABS0_PIN_A];
    else if (is_func(cfg[mgb_pkg::MOD_ABS0_PIN_B], mgb_pkg::FN_MOD_ABS))
      next_module_absent[0] = sync2[mgb_pkg::MOD_ABS0_PIN_B];
    next_module_absent[1] =
      is_func(cfg[mgb_pkg::MOD_ABS1_PIN], mgb_pkg::FN_MOD_ABS)
      && sync2[mgb_pkg::MOD_ABS1_PIN];
    next_read.cfg         = next_cfg[i_read_pin];
    next_read.pin_level   = sync2[i_read_pin]; // R03
    next_read.irq_pending = next_pending[i_read_pin];
  end

  // Samplers reset to the idle level of a pulled-up pad, so that no false
  // change is flagged as soon as reset ends.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sync1           <= '1;
      sync2           <= '1;
      prev            <= '1;
      pending         <= '0;
      pull            <= '0;
      o_master_ready  <= 2'h0;
      o_module_absent <= 2'h0;
      o_read_data     <= '0;
    end else begin
      sync1           <= i_pin;
      sync2           <= sync1;
      prev            <= sync2; // R12
      pending         <= next_pending;
      pull            <= next_pull;
      o_master_ready  <= next_master_ready; // R11
      o_module_absent <= next_module_absent;
      o_read_data     <= next_read;
    end
  end

  // Releasing the pad lets the external pull-up make the high level.
  assign o_pin         = '0; // R01
  assign o_pin_oe      = pull; // R01
  assign o_irq_pending = pending;
  assign o_pin_level   = sync2; // R03
  assign o_aux_in      = sync2;
  assign o_slave_sda   =
    is_func(cfg[mgb_pkg::SLAVE_SDA_PIN], mgb_pkg::FN_SLAVE_TWI)
    ? sync2[mgb_pkg::SLAVE_SDA_PIN] : 1'b1;
  assign o_slave_scl   =
    is_func(cfg[mgb_pkg::SLAVE_SCL_PIN], mgb_pkg::FN_SLAVE_TWI)
    ? sync2[mgb_pkg::SLAVE_SCL_PIN] : 1'b1;
  assign o_master_sda[0] = o_master_ready[0]
    ? sync2[mgb_pkg::MASTER0_SDA_PIN] : 1'b1; // R11
  assign o_master_scl[0] = o_master_ready[0]
    ? sync2[mgb_pkg::MASTER0_SCL_PIN] : 1'b1;
  assign o_master_sda[1] = o_master_ready[1]
    ? sync2[mgb_pkg::MASTER1_SDA_PIN] : 1'b1;
  assign o_master_scl[1] = o_master_ready[1]
    ? sync2[mgb_pkg::MASTER1_SCL_PIN] : 1'b1;

endmodule : mgb_bank

// ---- hdl/mgb_blink.sv ----
// Purpose: Blink-rate generator shared by all blinking plain I/O pins.
// Assumes: Runs on the core clock; HALF_CYCLES is the fastest half period.
// Notes:   Rate n toggles every 2**n base half periods.
`timescale 1ns/10ps
module mgb_blink #(
  parameter int HALF_CYCLES = mgb_pkg::BLINK_BASE_CYCLES,
  parameter int RATES       = mgb_pkg::RATE_COUNT
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  output logic      [RATES-1:0] o_phase
);

  localparam int CNT_W = $clog2(HALF_CYCLES + 1);

  if (HALF_CYCLES < 1 || RATES < 1) begin : g_bad_params
    $error("mgb_blink: HALF_CYCLES and RATES must be at least one.");
  end

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [RATES-1:0] next_phase;

  always_comb begin
    next_count = count + CNT_W'(1);
    next_phase = o_phase;
    if (count == CNT_W'(HALF_CYCLES - 1)) begin
      next_count = '0;
      next_phase = o_phase + RATES'(1);
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      count   <= '0;
      o_phase <= '0;
    end else begin
      count   <= next_count;
      o_phase <= next_phase;
    end
  end

endmodule : mgb_blink

// ---- hdl/mgb_pkg.sv ----
// Purpose: Shared constants and types of the multifunction pin bank.
// Assumes: One 50 MHz core clock and an asynchronous active-high reset.
// Notes:   Function and internal-signal codes are local encodings.
package mgb_pkg;

  localparam int PIN_COUNT     = 16;
  localparam int PIN_IDX_W     = 4;
  localparam int OBS_COUNT     = 8;
  localparam int OBS_SEL_W     = 3;
  localparam int RATE_COUNT    = 4;
  localparam int RATE_SEL_W    = 2;

  localparam int CLOCK_HZ      = 50_000_000;
  localparam int BLINK_BASE_MS = 125;
  localparam int BLINK_BASE_CYCLES = (CLOCK_HZ / 1000) * BLINK_BASE_MS;

  localparam logic [15:0] SLAVE_SDA_PINS  = 16'h0004;
  localparam logic [15:0] SLAVE_SCL_PINS  = 16'h0008;
  localparam logic [15:0] MASTER_PINS     = 16'h0cc0;
  localparam logic [15:0] MOD_ABS_PINS    = 16'h0301;
  localparam logic [15:0] TICK_PINS       = 16'h0301;
  localparam logic [15:0] IRQ_B_PINS      = 16'h045d;
  localparam int          SLAVE_SDA_PIN   = 2;
  localparam int          SLAVE_SCL_PIN   = 3;
  localparam int          MASTER0_SDA_PIN = 6;
  localparam int          MASTER0_SCL_PIN = 7;
  localparam int          MASTER1_SDA_PIN = 10;
  localparam int          MASTER1_SCL_PIN = 11;
  localparam int          MOD_ABS0_PIN_A  = 0;
  localparam int          MOD_ABS0_PIN_B  = 8;
  localparam int          MOD_ABS1_PIN    = 9;

  typedef enum logic [3:0] {
    FN_IO         = 4'h0,
    FN_OBSERVE    = 4'h1,
    FN_SLAVE_TWI  = 4'h2,
    FN_MASTER_TWI = 4'h3,
    FN_MOD_ABS    = 4'h4,
    FN_TX_LED     = 4'h5,
    FN_RX_LED     = 4'h6,
    FN_WAN_IRQ    = 4'h7,
    FN_TICK       = 4'h8,
    FN_AUX        = 4'h9
  } mgb_func_t;

  typedef struct packed {
    mgb_func_t              func;
    logic                   drive_en;
    logic                   level;
    logic                   led_en;
    logic [RATE_SEL_W-1:0]  blink_rate;
    logic                   irq_en;
    logic [OBS_SEL_W-1:0]   signal_select;
  } mgb_cfg_t;

  typedef struct packed {
    mgb_cfg_t cfg;
    logic     pin_level;
    logic     irq_pending;
  } mgb_status_t;

  localparam mgb_cfg_t CFG_RESET_IO = '{
    func: FN_IO, drive_en: 1'b0, level: 1'b1, led_en: 1'b0,
    blink_rate: 2'h0, irq_en: 1'b0, signal_select: 3'h0};

  localparam mgb_cfg_t CFG_RESET_SLAVE = '{
    func: FN_SLAVE_TWI, drive_en: 1'b0, level: 1'b1, led_en: 1'b0,
    blink_rate: 2'h0, irq_en: 1'b0, signal_select: 3'h0};

endpackage : mgb_pkg

// ---- tb/mgb_bank_checker.sv ----
// Purpose: Port-level assertions for the multifunction pin bank.
// Assumes: One clock domain with an asynchronous active-high reset.
// Notes:   The sync check waits until both input flops hold real samples.
`timescale 1ns/10ps
module mgb_bank_checker #(
  parameter int PINS = 16,
  parameter int OBS  = 8
) (
  input wire logic                          i_clock,
  input wire logic                          i_reset,
  input wire logic [PINS-1:0]               i_pin,
  input wire logic [PINS-1:0]               o_pin,
  input wire logic [PINS-1:0]               o_pin_oe,
  input wire logic                          i_cfg_write,
  input wire logic [mgb_pkg::PIN_IDX_W-1:0] i_cfg_pin,
  input wire mgb_pkg::mgb_cfg_t             i_cfg_data,
  input wire logic [mgb_pkg::PIN_IDX_W-1:0] i_read_pin,
  input wire mgb_pkg::mgb_status_t          o_read_data,
  input wire logic [PINS-1:0]               i_irq_clear,
  input wire logic [PINS-1:0]               o_irq_pending,
  input wire logic [PINS-1:0]               o_pin_level,
  input wire logic [OBS-1:0]                i_observe,
  input wire logic [1:0]                    o_master_ready,
  input wire logic [1:0]                    o_master_sda,
  input wire logic [1:0]                    o_master_scl
);
  logic [1:0] since;
  logic [1:0] next_since;
  always_comb begin
    next_since = (since == 2'h3) ? since : since + 2'h1;
  end
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      since <= 2'h0;
    end else begin
      since <= next_since;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence s_lone_write;
    i_cfg_write ##1 !i_cfg_write;
  endsequence
  property p_open_drain;
    o_pin == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pad output value not zero");
  property p_level;
    (i_cfg_data.func == mgb_pkg::FN_IO && i_cfg_data.drive_en &&
     !i_cfg_data.led_en) ##0 s_lone_write
    |=> o_pin_oe[$past(i_cfg_pin, 2)] == !$past(i_cfg_data.level, 2);
  endproperty
  a_level: assert property (p_level)
    else $error("driven level does not follow config");
  property p_observe;
    (i_cfg_data.func == mgb_pkg::FN_OBSERVE) ##0 s_lone_write
    |=> o_pin_oe[$past(i_cfg_pin, 2)] ==
        !i_observe[$past(i_cfg_data.signal_select, 2)];
  endproperty
  a_observe: assert property (p_observe)
    else $error("observed signal not on pin");
  property p_read_cfg;
    i_cfg_write && i_read_pin == i_cfg_pin
    |=> o_read_data.cfg == $past(i_cfg_data);
  endproperty
  a_read_cfg: assert property (p_read_cfg)
    else $error("status does not show written config");
  property p_sync;
    since == 2'h3 |-> o_pin_level == $past(i_pin, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("pin level not two samples behind pad");
  property p_pend_hold;
    (~o_irq_pending & $past(o_irq_pending) & ~$past(i_irq_clear) &
     ~$past(i_irq_clear, 2)) == '0;
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("pending dropped without clear");
  property p_pend_cause;
    (o_irq_pending & ~$past(o_irq_pending) &
     ~($past(o_pin_level) ^ $past(o_pin_level, 2))) == '0;
  endproperty
  a_pend_cause: assert property (p_pend_cause)
    else $error("pending set without level change");
  property p_master;
    !o_master_ready[0] |-> o_master_sda[0] && o_master_scl[0];
  endproperty
  a_master: assert property (p_master)
    else $error("master lines active while not ready");
  property p_master_follow;
    (!o_master_ready[0] || (o_master_sda[0] == o_pin_level[6]
                            && o_master_scl[0] == o_pin_level[7])) &&
    (!o_master_ready[1] || (o_master_sda[1] == o_pin_level[10]
                            && o_master_scl[1] == o_pin_level[11]));
  endproperty
  a_master_follow: assert property (p_master_follow)
    else $error("master lines do not follow their pins");
endmodule : mgb_bank_checker

// ---- tb/mgb_bank_test.sv ----
// Purpose: Self-checking bench for the multifunction pin bank.
// Assumes: Inputs change on the falling edge; short blink half period.
// Notes:   Config writes return once the pad driver has settled.
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module mgb_bank_test;
  localparam int HALF = 4;
  logic               i_clock = 1'b0;
  logic               i_reset = 1'b1;
  logic               cfg_write = 1'b0;
  logic [3:0]         cfg_pin = 4'h0;
  logic [3:0]         read_pin = 4'h0;
  mgb_pkg::mgb_cfg_t  cfg_data = mgb_pkg::CFG_RESET_IO;
  mgb_pkg::mgb_cfg_t  ec;
  mgb_pkg::mgb_status_t o_read_data;
  logic [15:0]        ext_low = 16'h0000;
  logic [15:0]        irq_clear = 16'h0000;
  logic [15:0]        pad, o_pin, o_pin_oe, o_irq_pending, o_pin_level;
  logic [7:0]         observe = 8'hff;
  logic               slave_pull = 1'b0;
  logic [15:0]        o_aux_in;
  logic               o_slave_sda, o_slave_scl;
  logic [1:0]         msda_pull = 2'h0, mscl_pull = 2'h0;
  logic [1:0]         o_master_sda, o_master_ready;
  logic [1:0]         o_master_scl, o_module_absent;
  logic [5:0]         ev = 6'h00;
  int                 mismatches = 0;
  int                 tests_run = 0;
  int                 n;
  logic [3:0] ev_func [6] = '{mgb_pkg::FN_TX_LED, mgb_pkg::FN_RX_LED,
    mgb_pkg::FN_WAN_IRQ, mgb_pkg::FN_WAN_IRQ, mgb_pkg::FN_TICK,
    mgb_pkg::FN_AUX};
  int         ev_pin  [6] = '{0, 1, 0, 1, 8, 5};
  always #10 i_clock = ~i_clock;
  mgb_board board_u (.i_pull_low_dev(o_pin_oe), .i_pull_low_ext(ext_low),
    .o_pad(pad));
  mgb_bank #(.BLINK_HALF(HALF)) dut_u (.i_clock(i_clock), .i_reset(i_reset),
    .i_pin(pad), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .i_cfg_write(cfg_write), .i_cfg_pin(cfg_pin), .i_cfg_data(cfg_data),
    .i_read_pin(read_pin), .o_read_data(o_read_data),
    .i_irq_clear(irq_clear), .o_irq_pending(o_irq_pending),
    .o_pin_level(o_pin_level), .i_observe(observe),
    .i_slave_sda_pull(slave_pull), .o_slave_sda(o_slave_sda),
    .o_slave_scl(o_slave_scl), .i_master_sda_pull(msda_pull),
    .i_master_scl_pull(mscl_pull), .o_master_sda(o_master_sda),
    .o_master_scl(o_master_scl), .o_master_ready(o_master_ready),
    .o_module_absent(o_module_absent), .i_perf_monitor_tick(ev[4]),
    .i_wan_sublayer_irq_a(ev[3]), .i_wan_sublayer_irq_b(ev[2]),
    .i_tx_activity(ev[0]), .i_rx_activity(ev[1]),
    .i_aux_out({16{~ev[5]}}), .o_aux_in(o_aux_in));
  // Low bits: drive_en, level, led_en, rate[1:0], irq_en, select[2:0].
  function automatic mgb_pkg::mgb_cfg_t mk(input logic [3:0] f,
                                           input logic [8:0] b);
    return mgb_pkg::mgb_cfg_t'({f, b});
  endfunction : mk
  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input int p, input mgb_pkg::mgb_cfg_t c);
    @(negedge i_clock);
    cfg_write = 1'b1;
    cfg_pin = p[3:0];
    read_pin = p[3:0];
    cfg_data = c;
    @(negedge i_clock);
    cfg_write = 1'b0;
    repeat (2) @(negedge i_clock);
  endtask : wr
  task automatic wt(input int p, input logic v);
    int t;
    t = 0;
    while (o_pin_oe[p] !== v && t < 300) begin
      @(negedge i_clock);
      t++;
    end
    if (t == 300) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : wt
  initial begin
    repeat (12) @(negedge i_clock);
    i_reset = 1'b0;
    for (int k = 0; k < 16; k++) begin
      read_pin = k[3:0];
      @(negedge i_clock);
      ec = (k == 2 || k == 3) ? mgb_pkg::CFG_RESET_SLAVE
                              : mgb_pkg::CFG_RESET_IO;
      `CHK("reset cfg", ec, o_read_data.cfg)
    end
    `CHK("reset oe", 16'h0000, o_pin_oe)
    slave_pull = 1'b1;
    ext_low = 16'h0008;
    repeat (4) @(negedge i_clock);
    `CHK("slave sda", 2'b10, {o_pin_oe[2], o_slave_sda})
    `CHK("slave scl", 1'b0, o_slave_scl)
    slave_pull = 1'b0;
    ext_low = 16'h0000;
    wr(5, mk(mgb_pkg::FN_IO, 9'h100));
    `CHK("drive low", 1'b1, o_pin_oe[5])
    wr(5, mk(mgb_pkg::FN_IO, 9'h180));
    `CHK("drive high", 1'b0, o_pin_oe[5])
    wr(12, mk(mgb_pkg::FN_IO, 9'h008));
    wr(13, mk(mgb_pkg::FN_IO, 9'h000));
    ext_low = 16'h3000;
    repeat (4) @(negedge i_clock);
    `CHK("input level", 2'b00, o_pin_level[13:12])
    `CHK("aux in", 2'b00, o_aux_in[13:12])
    `CHK("pending set", 2'b01, o_irq_pending[13:12])
    ext_low = 16'h0000;
    read_pin = 4'hc;
    repeat (4) @(negedge i_clock);
    `CHK("status level", 1'b1, o_read_data.pin_level)
    `CHK("pending held", 2'b01, o_irq_pending[13:12])
    irq_clear = 16'h1000;
    @(negedge i_clock);
    irq_clear = 16'h0000;
    repeat (2) @(negedge i_clock);
    `CHK("pending clear", 1'b0, o_irq_pending[12])
    for (int r = 0; r < 4; r++) begin
      wr(4, mk(mgb_pkg::FN_IO, 9'h140 | (9'(r) << 4)));
      wt(4, 1'b0);
      wt(4, 1'b1);
      n = 0;
      while (o_pin_oe[4] === 1'b1 && n < 100) begin
        @(negedge i_clock);
        n++;
      end
      `CHK("blink high", HALF << r, n)
    end
    for (int s = 0; s < 8; s++) begin
      observe = ~(8'h01 << s);
      wr(9, mk(mgb_pkg::FN_OBSERVE, 9'(s)));
      `CHK("observe low", 1'b1, o_pin_oe[9])
      observe = 8'hff;
      repeat (2) @(negedge i_clock);
      `CHK("observe high", 1'b0, o_pin_oe[9])
    end
    for (int i = 0; i < 6; i++) begin
      wr(ev_pin[i], mk(ev_func[i], 9'h000));
      ev = 6'h01 << i;
      repeat (2) @(negedge i_clock);
      `CHK("event on", 1'b1, o_pin_oe[ev_pin[i]])
      ev = 6'h00;
      repeat (2) @(negedge i_clock);
      `CHK("event off", 1'b0, o_pin_oe[ev_pin[i]])
      wr(ev_pin[i], mk(mgb_pkg::FN_IO, 9'h000));
    end
    wr(9, mk(mgb_pkg::FN_MOD_ABS, 9'h000));
    `CHK("absent high", 2'b10, o_module_absent)
    ext_low = 16'h0200;
    repeat (4) @(negedge i_clock);
    `CHK("absent low", 2'b00, o_module_absent)
    ext_low = 16'h0000;
    for (int c = 0; c < 2; c++) begin
      wr(6 + 4 * c, mk(mgb_pkg::FN_MASTER_TWI, 9'h000));
      `CHK("half master", 1'b0, o_master_ready[c])
      wr(7 + 4 * c, mk(mgb_pkg::FN_MASTER_TWI, 9'h000));
      msda_pull = 2'h1 << c;
      repeat (3) @(negedge i_clock);
      `CHK("master on", 3'b110, {o_master_ready[c], o_pin_oe[6 + 4 * c],
                                 o_master_sda[c]})
      msda_pull = 2'h0;
      mscl_pull = 2'h1 << c;
      repeat (3) @(negedge i_clock);
      `CHK("master scl", 2'b10, {o_pin_oe[7 + 4 * c],
                                 o_master_scl[c]})
      mscl_pull = 2'h0;
      wr(6 + 4 * c, mk(mgb_pkg::FN_IO, 9'h000));
      `CHK("master off", 1'b0, o_master_ready[c])
    end
    tally_and_finish();
  end
endmodule : mgb_bank_test
bind mgb_bank mgb_bank_checker #(.PINS(PINS), .OBS(OBS)) chk_u (
  .i_clock, .i_reset, .i_pin, .o_pin, .o_pin_oe, .i_cfg_write, .i_cfg_pin,
  .i_cfg_data, .i_read_pin, .o_read_data, .i_irq_clear, .o_irq_pending,
  .o_pin_level, .i_observe, .o_master_ready, .o_master_sda, .o_master_scl);

// ---- tb/mgb_board.sv ----
// Purpose: Board model of pull-ups and external drivers on the pads.
// Assumes: Every pad has a pull-up and any driver only pulls low.
// Notes:   A released pad reads high, so no stale drive value lingers.
`timescale 1ns/10ps
module mgb_board (
  input  wire logic [15:0] i_pull_low_dev,
  input  wire logic [15:0] i_pull_low_ext,
  output logic      [15:0] o_pad
);
  assign o_pad = ~(i_pull_low_dev | i_pull_low_ext);
endmodule : mgb_board
